// *** lpc_capture_map.svh ***
`ifndef LPC_CAPTURE_MAP_SVH
`define LPC_CAPTURE_MAP_SVH
// How it works
// [R1] Frames per multiframe minus one kept in 5 bits; 0x0f or 0x1f valid.
// [R2] Converter count minus one kept in 8 bits; sender gives 0, 1 or 3.
// [R3] Sender gives zero control bits; received value shown in bits 7:6.
// [R4] Resolution minus one in 5 bits; sender must give 0x0f.
// [R5] Bits per sample minus one in 5 bits; sender must give 0x0f.
// [R6] Subclass version kept in bits 7:5 beside bits per sample.
// [R7] Standard version kept in 3 bits; 000 first revision, 001 second.
// [R8] Samples per frame minus one in 5 bits; only 0 or 1 valid.
// [R9] Density flag in bit 7: 0 low density, 1 high density.
// [R10] Sender gives zero control words; count shown in 5 bits.
// [R11] First reserved configuration octet kept whole, read only.
// [R12] Checksum computed over lane 0 configuration data for software.
// [R13] Captures clear to zero, ignore writes, reserved bits read zero.

// ****************************************
// Register offsets
// ****************************************
`define LPC_OFS_FRAMES 12'h405
`define LPC_OFS_CONV 12'h406
`define LPC_OFS_CSRES 12'h407
`define LPC_OFS_SCNP 12'h408
`define LPC_OFS_VERS 12'h409
`define LPC_OFS_HDCF 12'h40a
`define LPC_OFS_RES1 12'h40b
`define LPC_OFS_CHK 12'h40e

// ****************************************
// Octet positions in the configuration data
// ****************************************
`define LPC_OCT_FIRST 4'h0
`define LPC_OCT_FRAMES 4'h5
`define LPC_OCT_CONV 4'h6
`define LPC_OCT_CSRES 4'h7
`define LPC_OCT_SCNP 4'h8
`define LPC_OCT_VERS 4'h9
`define LPC_OCT_HDCF 4'ha
`define LPC_OCT_RES1 4'hb
`define LPC_OCT_LAST 4'hc

// ****************************************
// Reset value and legal settings
// ****************************************
`define LPC_REG_RST 8'h00
`define LPC_FPM16 5'h0f
`define LPC_FPM32 5'h1f
`define LPC_CONV1 8'h00
`define LPC_CONV2 8'h01
`define LPC_CONV4 8'h03
`define LPC_RES16 5'h0f
`define LPC_SPF1 5'h00
`define LPC_SPF2 5'h01
`endif

// *** lpc_pkg.sv ***
package lpc_pkg;
    // One configuration octet from the lane 0 alignment sequence
    typedef struct packed {
        logic valid;
        logic [3:0] index;
        logic [7:0] data;
    } lpc_octet_t;
    // Register request from the serial control port
    typedef struct packed {
        logic rd;
        logic wr;
        logic [11:0] addr;
        logic [7:0] wdata;
    } lpc_req_t;
    // Register answer
    typedef struct packed {
        logic valid;
        logic [7:0] data;
    } lpc_rsp_t;
endpackage : lpc_pkg

// *** lpc_capture_regs.sv ***
`timescale 1ns/1ps
`include "lpc_capture_map.svh"
module lpc_capture_regs (
    // Clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // Lane 0 configuration octets
    input wire lpc_pkg::lpc_octet_t cfgIn,
    // Serial control register port
    input wire lpc_pkg::lpc_req_t regReq,
    output lpc_pkg::lpc_rsp_t regRsp,
    // Status
    output logic cfgDone,
    output logic cfgLegal
);

    // ****************************************
    // Captured parameter registers
    // ****************************************
    logic [7:0] framesReg;
    logic [7:0] convReg;
    logic [7:0] csResReg;
    logic [7:0] scNpReg;
    logic [7:0] versReg;
    logic [7:0] hdCfReg;
    logic [7:0] res1Reg;
    logic [7:0] chkReg;
    logic [7:0] sumAcc;
    logic [7:0] next_rdata;
    logic next_legal;
    logic takeOct;

    assign takeOct = cfgIn.valid;

    // Frames per multiframe, upper bits held at zero
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            framesReg <= `LPC_REG_RST; // R13
        end else if (takeOct && cfgIn.index == `LPC_OCT_FRAMES) begin
            framesReg <= {3'h0, cfgIn.data[4:0]}; // R1
        end
    end

    // Converter count kept whole
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            convReg <= `LPC_REG_RST;
        end else if (takeOct && cfgIn.index == `LPC_OCT_CONV) begin
            convReg <= cfgIn.data; // R2
        end
    end

    // Control bits and resolution; bit 5 reserved
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            csResReg <= `LPC_REG_RST;
        end else if (takeOct && cfgIn.index == `LPC_OCT_CSRES) begin
            csResReg <= {cfgIn.data[7:6], 1'h0, cfgIn.data[4:0]}; // R3 R4
        end
    end

    // Subclass version and bits per sample share one octet
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            scNpReg <= `LPC_REG_RST;
        end else if (takeOct && cfgIn.index == `LPC_OCT_SCNP) begin
            scNpReg <= cfgIn.data; // R5 R6
        end
    end

    // Standard version and samples per frame
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            versReg <= `LPC_REG_RST;
        end else if (takeOct && cfgIn.index == `LPC_OCT_VERS) begin
            versReg <= cfgIn.data; // R7 R8
        end
    end

    // Density flag and control words; bits 6:5 reserved
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            hdCfReg <= `LPC_REG_RST;
        end else if (takeOct && cfgIn.index == `LPC_OCT_HDCF) begin
            hdCfReg <= {cfgIn.data[7], 2'h0, cfgIn.data[4:0]}; // R9 R10
        end
    end

    // First reserved octet, kept whole
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            res1Reg <= `LPC_REG_RST;
        end else if (takeOct && cfgIn.index == `LPC_OCT_RES1) begin
            res1Reg <= cfgIn.data; // R11
        end
    end

    // ****************************************
    // Checksum over the configuration octets
    // ****************************************
    // Running sum restarts on the first octet, so a repeated
    // alignment sequence never mixes with the previous one.
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            sumAcc <= `LPC_REG_RST;
        end else if (takeOct && cfgIn.index == `LPC_OCT_FIRST) begin
            sumAcc <= cfgIn.data; // R12
        end else if (takeOct) begin
            sumAcc <= sumAcc + cfgIn.data; // R12
        end
    end

    // Result latched on the last summed octet, modulo 256
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            chkReg <= `LPC_REG_RST;
        end else if (takeOct && cfgIn.index == `LPC_OCT_LAST) begin
            chkReg <= sumAcc + cfgIn.data; // R12
        end
    end

    // Done marks a full set; a fresh first octet withdraws it
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            cfgDone <= 1'b0;
        end else if (takeOct && cfgIn.index == `LPC_OCT_LAST) begin
            cfgDone <= 1'b1;
        end else if (takeOct && cfgIn.index == `LPC_OCT_FIRST) begin
            cfgDone <= 1'b0;
        end
    end

    // ****************************************
    // Legality of the advertised parameters
    // ****************************************
    // Checks what the sender is bound to; the device only reports.
    always_comb begin
        next_legal = 1'b1;
        if (framesReg[4:0] != `LPC_FPM16 && framesReg[4:0] != `LPC_FPM32) begin
            next_legal = 1'b0; // R1
        end
        if (convReg != `LPC_CONV1 && convReg != `LPC_CONV2 &&
            convReg != `LPC_CONV4) begin
            next_legal = 1'b0; // R2
        end
        if (csResReg[7:6] != 2'h0) begin
            next_legal = 1'b0; // R3
        end
        if (csResReg[4:0] != `LPC_RES16) begin
            next_legal = 1'b0; // R4
        end
        if (scNpReg[4:0] != `LPC_RES16) begin
            next_legal = 1'b0; // R5
        end
        if (versReg[4:0] != `LPC_SPF1 && versReg[4:0] != `LPC_SPF2) begin
            next_legal = 1'b0; // R8
        end
        if (hdCfReg[4:0] != 5'h00) begin
            next_legal = 1'b0; // R10
        end
        if (!cfgDone) begin
            next_legal = 1'b0;
        end
    end

    // Registered so the status pin comes from a flip-flop
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            cfgLegal <= 1'b0;
        end else begin
            cfgLegal <= next_legal;
        end
    end

    // ****************************************
    // Register read port
    // ****************************************
    // Read mux; unmapped offsets answer zero
    always_comb begin
        case (regReq.addr)
            `LPC_OFS_FRAMES: next_rdata = framesReg;
            `LPC_OFS_CONV: next_rdata = convReg;
            `LPC_OFS_CSRES: next_rdata = csResReg;
            `LPC_OFS_SCNP: next_rdata = scNpReg;
            `LPC_OFS_VERS: next_rdata = versReg;
            `LPC_OFS_HDCF: next_rdata = hdCfReg;
            `LPC_OFS_RES1: next_rdata = res1Reg;
            `LPC_OFS_CHK: next_rdata = chkReg;
            default: next_rdata = 8'h00;
        endcase
    end

    // One cycle read latency; writes are simply dropped
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            regRsp <= '0;
        end else begin
            regRsp.valid <= regReq.rd; // R13
            regRsp.data <= regReq.rd ? next_rdata : 8'h00;
        end
    end

    // ****************************************
    // Assertions
    // ****************************************
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!rst_n);

    sequence octAt(logic [3:0] idx);
        cfgIn.valid && cfgIn.index == idx;
    endsequence

    sequence sumStart;
        octAt(`LPC_OCT_FIRST);
    endsequence

    sequence rdAt(logic [11:0] a);
        regReq.rd && regReq.addr == a;
    endsequence

    frames_capture_a: assert property ( // R1
        octAt(`LPC_OCT_FRAMES) |=> framesReg[7:5] == 3'h0 &&
            framesReg[4:0] == $past(cfgIn.data[4:0]))
        else $error("frames field not captured");

    conv_capture_a: assert property ( // R2
        octAt(`LPC_OCT_CONV) |=> convReg == $past(cfgIn.data))
        else $error("converter count not captured");

    csres_capture_a: assert property ( // R4
        octAt(`LPC_OCT_CSRES) |=> csResReg[5] == 1'b0 &&
            csResReg[7:6] == $past(cfgIn.data[7:6]) &&
            csResReg[4:0] == $past(cfgIn.data[4:0]))
        else $error("control bits or resolution wrong");

    subclass_capture_a: assert property ( // R6
        octAt(`LPC_OCT_SCNP) |=> scNpReg[7:5] == $past(cfgIn.data[7:5])
            && scNpReg[4:0] == $past(cfgIn.data[4:0]))
        else $error("subclass or sample bits wrong");

    version_capture_a: assert property ( // R7
        octAt(`LPC_OCT_VERS) |=> versReg == $past(cfgIn.data))
        else $error("version octet not captured");

    density_capture_a: assert property ( // R9
        octAt(`LPC_OCT_HDCF) |=> hdCfReg[7] == $past(cfgIn.data[7]) &&
            hdCfReg[6:5] == 2'h0)
        else $error("density flag wrong");

    ctrl_words_a: assert property ( // R10
        octAt(`LPC_OCT_HDCF) |=> hdCfReg[4:0] == $past(cfgIn.data[4:0]))
        else $error("control word count wrong");

    reserved_octet_a: assert property ( // R11
        octAt(`LPC_OCT_RES1) |=> res1Reg == $past(cfgIn.data))
        else $error("reserved octet not captured");

    // Sum restarts on octet 0, so stale sets never leak into a new one
    sum_restart_a: assert property ( // R12
        sumStart |=> sumAcc == $past(cfgIn.data) && !cfgDone)
        else $error("checksum did not restart");

    checksum_result_a: assert property ( // R12
        octAt(`LPC_OCT_LAST) |=>
            chkReg == 8'($past(sumAcc) + $past(cfgIn.data)) && cfgDone)
        else $error("checksum result wrong");

    checksum_read_a: assert property ( // R12
        rdAt(`LPC_OFS_CHK) |=> regRsp.valid && regRsp.data == $past(chkReg))
        else $error("checksum read wrong");

    read_answer_a: assert property ( // R13
        regReq.rd && regReq.addr == `LPC_OFS_FRAMES |=>
            regRsp.valid && regRsp.data == $past(framesReg))
        else $error("read answer wrong");

    write_ignored_a: assert property ( // R13
        regReq.wr && !cfgIn.valid |=> $stable(convReg) &&
            $stable(res1Reg) && $stable(chkReg))
        else $error("write changed a capture");

    // Holes in the map answer zero rather than a stale capture
    unmapped_zero_a: assert property ( // R13
        rdAt(12'h40c) |=> regRsp.valid && regRsp.data == 8'h00)
        else $error("unmapped read not zero");

    idle_quiet_a: assert property ( // R13
        !regReq.rd |=> !regRsp.valid && regRsp.data == 8'h00)
        else $error("answer without a read");

    legal_needs_done_a: assert property ( // R1
        cfgLegal |-> $past(cfgDone))
        else $error("legal before a full set");

    frames_legal_a: assert property ( // R1
        cfgLegal |-> $past(framesReg[4:0]) inside {`LPC_FPM16, `LPC_FPM32})
        else $error("legal with bad frame count");

    legal_conv_a: assert property ( // R2
        cfgLegal |-> $past(convReg) inside {`LPC_CONV1, `LPC_CONV2,
            `LPC_CONV4})
        else $error("legal with bad converter count");

endmodule : lpc_capture_regs

// *** lpc_lane_sender.sv ***
`timescale 1ns/1ps
// ********************
// Lane 0 sender model
// ********************
module lpc_lane_sender (
    // Clock
    input wire logic clk,
    // Control from the bench
    input wire logic start,
    input wire logic [3:0] gap,
    input wire logic [103:0] octets,
    // Octet stream and state
    output lpc_pkg::lpc_octet_t cfgOut,
    output logic busy
);
    // Octets 0..12 in order; gap idles between them for a slow sender
    initial begin
        cfgOut = '0;
        busy = 1'b0;
        forever begin
            @(posedge clk);
            if (start) begin
                busy <= 1'b1;
                for (int i = 0; i < 13; i++) begin
                    cfgOut <= '{1'b1, 4'(i), octets[8*i +: 8]};
                    @(posedge clk);
                    // Released lines show garbage, never the old octet
                    if (gap != 4'h0 || i == 12) begin
                        cfgOut <= '{1'b0, ~4'(i), ~octets[8*i +: 8]};
                    end
                    repeat (gap) @(posedge clk);
                end
                busy <= 1'b0;
            end
        end
    end
endmodule : lpc_lane_sender

// *** link_param_capture_regs_tb.sv ***
`timescale 1ns/1ps
`include "lpc_capture_map.svh"
module link_param_capture_regs_tb;
    logic clk;
    logic rst_n;
    logic start;
    logic [3:0] gap;
    logic [103:0] octets;
    logic busy;
    logic cfgDone;
    logic cfgLegal;
    lpc_pkg::lpc_octet_t cfgIn;
    lpc_pkg::lpc_req_t regReq;
    lpc_pkg::lpc_rsp_t regRsp;
    int nFail;
    int numChecks;
    logic [7:0] expReg [8];
    logic [11:0] ofs [8] = '{`LPC_OFS_FRAMES, `LPC_OFS_CONV, `LPC_OFS_CSRES,
        `LPC_OFS_SCNP, `LPC_OFS_VERS, `LPC_OFS_HDCF, `LPC_OFS_RES1,
        `LPC_OFS_CHK};
    // Reserved bits of the captures read as zero
    logic [7:0] keep [7] = '{8'h1f, 8'hff, 8'hdf, 8'hff, 8'hff, 8'h9f, 8'hff};

    // ********************
    // Design and far side
    // ********************
    lpc_capture_regs i_dut (.clk(clk), .rst_n(rst_n), .cfgIn(cfgIn),
        .regReq(regReq), .regRsp(regRsp), .cfgDone(cfgDone),
        .cfgLegal(cfgLegal));
    lpc_lane_sender i_tx (.clk(clk), .start(start), .gap(gap),
        .octets(octets), .cfgOut(cfgIn), .busy(busy));

    initial begin
        clk = 1'b0;
        forever #2.5 clk = ~clk;
    end

    // ********************
    // Checking helpers
    // ********************
    task automatic finalReport();
        $display("Checks %0d mismatches %0d", numChecks, nFail);
        if (nFail == 0 && numChecks > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask : finalReport

    task automatic chk8(string what, logic [7:0] exp, logic [7:0] got);
        numChecks++;
        if (got !== exp) begin
            nFail++;
            $display("MISMATCH %s expected %h seen %h", what, exp, got);
        end
    endtask : chk8

    task automatic chkBit(string what, logic exp, logic got);
        numChecks++;
        if (got !== exp) begin
            nFail++;
            $display("MISMATCH %s expected %b seen %b", what, exp, got);
        end
    endtask : chkBit

    // One-cycle strobe; answer stands in the cycle after the take edge
    task automatic readReg(logic [11:0] a, logic [7:0] exp);
        @(posedge clk);
        regReq <= '{1'b1, 1'b0, a, 8'h00};
        @(posedge clk);
        regReq <= '0;
        #1;
        chkBit("rspValid", 1'b1, regRsp.valid);
        chk8($sformatf("reg %h", a), exp, regRsp.data);
    endtask : readReg

    task automatic writeAll();
        for (int k = 0; k < 8; k++) begin
            @(posedge clk);
            regReq <= '{1'b0, 1'b1, ofs[k], 8'($urandom)};
            @(posedge clk);
            regReq <= '0;
        end
    endtask : writeAll

    task automatic checkAll();
        for (int k = 0; k < 8; k++) begin
            readReg(ofs[k], expReg[k]);
        end
    endtask : checkAll

    // Model: masked captures, byte sum of octets 0..12
    task automatic sendCfg(bit legal);
        logic [7:0] o [13];
        logic [7:0] sum;
        logic [7:0] conv [3] = '{`LPC_CONV1, `LPC_CONV2, `LPC_CONV4};
        int n;
        sum = 8'h00;
        foreach (o[i]) o[i] = 8'($urandom);
        o[5] = 8'h05;
        if (legal) begin
            o[5] = $urandom_range(1, 0) ? 8'h1f : 8'h0f;
            o[6] = conv[$urandom_range(2, 0)];
            o[7] = 8'h0f;
            o[8] = 8'h2f;
            o[9] = {3'h1, 4'h0, 1'($urandom)};
            o[10] = {1'($urandom), 7'h00};
        end
        foreach (o[i]) begin
            octets[8*i +: 8] <= o[i];
            sum += o[i];
        end
        for (int k = 0; k < 7; k++) expReg[k] = o[k+5] & keep[k];
        expReg[7] = sum;
        gap <= 4'($urandom_range(2, 0));
        start <= 1'b1;
        @(posedge clk);
        start <= 1'b0;
        n = 0;
        do begin
            @(posedge clk);
            n++;
        end while (busy && n < 300);
        if (busy) begin
            nFail++;
            finalReport();
        end
        repeat (2) @(posedge clk);
        #1;
        chkBit("cfgDone", 1'b1, cfgDone);
        chkBit("cfgLegal", legal, cfgLegal);
    endtask : sendCfg

    // ********************
    // Main sequence
    // ********************
    initial begin
        rst_n = 1'b0;
        start = 1'b0;
        gap = 4'h0;
        octets = '0;
        regReq = '0;
        nFail = 0;
        numChecks = 0;
        foreach (expReg[k]) expReg[k] = 8'h00;
        void'($urandom(32'hfc5b));
        repeat (6) @(posedge clk);
        rst_n <= 1'b1;
        checkAll();
        readReg(12'h404, 8'h00);
        readReg(12'h40c, 8'h00);
        $display("Test reset values done");
        for (int t = 0; t < 4; t++) begin
            sendCfg(t % 2 == 0);
            writeAll();
            checkAll();
            readReg(12'h404, 8'h00);
            readReg(12'h40c, 8'h00);
            $display("Test capture %0d done", t);
        end
        @(posedge clk);
        rst_n <= 1'b0;
        repeat (2) @(posedge clk);
        #1;
        chkBit("cfgDone", 1'b0, cfgDone);
        chkBit("cfgLegal", 1'b0, cfgLegal);
        @(posedge clk);
        rst_n <= 1'b1;
        foreach (expReg[k]) expReg[k] = 8'h00;
        checkAll();
        $display("Test second reset done");
        finalReport();
    end
endmodule : link_param_capture_regs_tb
